//--- core/sfdpr_pkg.sv
// Package: constants for the discovery parameter store
package sfdpr_pkg;

  // ***************************************************************
  // Address map
  // ***************************************************************
  localparam int unsigned SFDPR_AW     = 16;           // Byte address width
  localparam logic [15:0] SFDPR_IDCFI_BASE = 16'h1000; // Parameter start
  localparam logic [15:0] SFDPR_CFI_BASE   = 16'h108e; // CFI-relative base
  localparam logic [15:0] SFDPR_SFDP_BASE  = 16'h1090; // SFDP-relative base
  localparam logic [15:0] SFDPR_CFI_SKEW   = 16'h0002; // SFDP minus CFI
  localparam logic [7:0]  SFDPR_NBYTES     = 8'h0e;    // CFI bytes 00h..0Dh
  localparam int unsigned SFDPR_IW         = 4;        // Table index width

  // ***************************************************************
  // Byte values
  // ***************************************************************
  localparam logic [7:0] SFDPR_PARAM_ID   = 8'ha5; // Discovery parameter id
  localparam logic [7:0] SFDPR_PARAM_LEN  = 8'hb0; // Bytes that follow
  localparam logic [7:0] SFDPR_DW1_B0     = 8'he7; // Capability bits
  localparam logic [7:0] SFDPR_DW1_B1     = 8'hff; // No 4KB erase opcode
  localparam logic [7:0] SFDPR_DW1_B2     = 8'hfb; // Read mode support
  localparam logic [7:0] SFDPR_DW1_B3     = 8'hff; // Unused byte
  localparam logic [7:0] SFDPR_DENS_LO    = 8'hff; // Density low bytes
  localparam logic [7:0] SFDPR_DENS_HI    = 8'h03; // Density top byte
  localparam logic [7:0] SFDPR_QIO_WAIT   = 8'h48; // 1-4-4 mode/dummy
  localparam logic [7:0] SFDPR_QIO_OP     = 8'heb; // 1-4-4 opcode
  localparam logic [7:0] SFDPR_QO_WAIT    = 8'h08; // 1-1-4 mode/dummy
  localparam logic [7:0] SFDPR_QO_OP      = 8'h6b; // 1-1-4 opcode
  localparam logic [7:0] SFDPR_BLANK      = 8'hff; // Unmapped byte value

  // Read pipeline states
  typedef enum logic [0:0] {SFDPR_IDLE, SFDPR_LOAD} sfdpr_state_e;

endpackage

//--- core/sfdpr_rom.sv
// Small registered lookup of the section-1 parameter bytes
`timescale 1ns/1ps

module sfdpr_rom
  import sfdpr_pkg::*;
(
  // Clock
  input  wire logic                ref_clk_i,
  // Lookup
  input  wire logic [SFDPR_IW-1:0] idx_i,
  output logic      [7:0]          data_o
);

  // ***************************************************************
  // Constant table, no write path exists at all
  // ***************************************************************
  logic [7:0] rom_d; // Combinational table value

  // Table lookup by CFI-relative index
  always_comb
  begin
    case (idx_i)
      4'h0:    rom_d = SFDPR_PARAM_ID;
      4'h1:    rom_d = SFDPR_PARAM_LEN;
      4'h2:    rom_d = SFDPR_DW1_B0;
      4'h3:    rom_d = SFDPR_DW1_B1;
      4'h4:    rom_d = SFDPR_DW1_B2;
      4'h5:    rom_d = SFDPR_DW1_B3;
      4'h6:    rom_d = SFDPR_DENS_LO;
      4'h7:    rom_d = SFDPR_DENS_LO;
      4'h8:    rom_d = SFDPR_DENS_LO;
      4'h9:    rom_d = SFDPR_DENS_HI;
      4'ha:    rom_d = SFDPR_QIO_WAIT;
      4'hb:    rom_d = SFDPR_QIO_OP;
      4'hc:    rom_d = SFDPR_QO_WAIT;
      4'hd:    rom_d = SFDPR_QO_OP;
      // Past the table; section 2 is not held in this store
      default: rom_d = SFDPR_BLANK;
    endcase
  end

  // Read data come out of a register
  always_ff @(posedge ref_clk_i)
  begin
    data_o <= rom_d;
  end

endmodule

//--- core/sfdpr_top.sv
// Discovery parameter store: section-1 basic parameter read port
`timescale 1ns/1ps

module sfdpr_top
  import sfdpr_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Read request from the discovery-read engine
  input  wire logic                 rd_req_i,
  input  wire logic [SFDPR_AW-1:0]  rd_addr_i,
  // Read answer
  output logic                      rd_valid_o,
  output logic                      rd_hit_o,
  output logic      [7:0]           rd_data_o
);

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic [SFDPR_AW-1:0] cfi_off;   // Offset from the CFI base
  logic                in_sec1;   // Address inside this table
  logic [SFDPR_IW-1:0] idx;       // Table index

  // Both views land on one table: the SFDP base sits two bytes above
  // the CFI base, so one subtraction serves both numberings.
  always_comb
  begin
    cfi_off = rd_addr_i - SFDPR_CFI_BASE;
    in_sec1 = (rd_addr_i >= SFDPR_CFI_BASE) &&
              (cfi_off < {8'h00, SFDPR_NBYTES});
    idx     = cfi_off[SFDPR_IW-1:0];
  end

  // ***************************************************************
  // Lookup table
  // ***************************************************************
  logic [7:0] rom_data; // Registered table byte

  // The table has no write port, so nothing a host does can alter it
  sfdpr_rom u_rom
  (
    .ref_clk_i (ref_clk_i),
    .idx_i     (idx),
    .data_o    (rom_data)
  );

  // ***************************************************************
  // Two-stage answer pipeline
  // ***************************************************************
  sfdpr_state_e state_q;   // LOAD while table read is in flight
  logic         hit_q;     // Request fell inside section 1

  // Track the request through the registered lookup
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SFDPR_IDLE;
      hit_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        SFDPR_IDLE:
        begin
          // Accept a request, remember whether it mapped
          if (rd_req_i)
          begin
            state_q <= SFDPR_LOAD;
          end
          hit_q <= in_sec1;
        end
        SFDPR_LOAD:
        begin
          // Table byte is ready now; a new request may follow at once
          state_q <= rd_req_i ? SFDPR_LOAD : SFDPR_IDLE;
          hit_q   <= in_sec1;
        end
        default:
        begin
          state_q <= SFDPR_IDLE;
          hit_q   <= 1'b0;
        end
      endcase
    end
  end

  // Answer registers; unmapped bytes read as all ones, which leaves room
  // for the density-dependent section 2 to be spliced in after 0Dh
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_hit_o   <= 1'b0;
      rd_data_o  <= SFDPR_BLANK;
    end
    else
    begin
      rd_valid_o <= (state_q == SFDPR_LOAD);
      rd_hit_o   <= (state_q == SFDPR_LOAD) && hit_q;
      if (state_q == SFDPR_LOAD)
      begin
        rd_data_o <= hit_q ? rom_data : SFDPR_BLANK;
      end
    end
  end

endmodule

//--- tb/sfdpr_host.sv
// Host model: issues single-byte discovery reads
`timescale 1ns/1ps

module sfdpr_host
(
  // Clock, reset and command from the bench
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic [15:0] a_i,
  // Read request toward the store
  output logic             req_o = 1'b0,
  output logic      [15:0] addr_o = 16'h0000
);
  // Reads only; an idle address toggles between its inverse and the last address
  always_ff @(posedge clk_i)
  begin
    req_o  <= go_i & rst_n_i;
    addr_o <= go_i ? a_i : ~addr_o;
  end
endmodule

//--- tb/sfdpr_top_assertions.sv
// Checker: timing and byte values of the parameter read port
`timescale 1ns/1ps

module sfdpr_top_chk
  import sfdpr_pkg::*;
(
  // Watched ports
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic        rd_valid_o,
  input wire logic        rd_hit_o,
  input wire logic [7:0]  rd_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Address lies inside the section-1 table
  wire logic in_t = rd_addr_i >= 16'h108e && rd_addr_i <= 16'h109b;
  a_id_byte: assert property (
    rd_req_i && rd_addr_i == 16'h108e |-> ##2 rd_data_o == 8'ha5)
    else $error("id byte");
  a_len_byte: assert property (
    rd_req_i && rd_addr_i == 16'h108f |-> ##2 rd_data_o == 8'hb0)
    else $error("length byte");
  a_cap_byte: assert property (
    rd_req_i && rd_addr_i == 16'h1090 |-> ##2 rd_data_o == 8'he7)
    else $error("capability byte");
  a_dens_top: assert property (
    rd_req_i && rd_addr_i == 16'h1097 |-> ##2 rd_data_o == 8'h03)
    else $error("density byte");
  a_qio_op: assert property (
    rd_req_i && rd_addr_i == 16'h1099 |-> ##2 rd_data_o == 8'heb)
    else $error("quad io opcode");
  a_qo_op: assert property (
    rd_req_i && rd_addr_i == 16'h109b |-> ##2 rd_data_o == 8'h6b)
    else $error("quad out opcode");
  a_map_hit: assert property (
    rd_req_i && in_t |-> ##2 rd_valid_o && rd_hit_o)
    else $error("table hit");
  a_miss_blank: assert property (
    rd_req_i && !in_t |-> ##2 rd_valid_o && !rd_hit_o && rd_data_o == 8'hff)
    else $error("miss value");
  a_hold_data: assert property (
    !rd_valid_o |-> $stable(rd_data_o))
    else $error("data moved");
  c_hit: cover property (rd_valid_o && rd_hit_o);
  c_miss: cover property (rd_valid_o && !rd_hit_o);
  c_b2b: cover property (rd_req_i ##1 rd_req_i);
endmodule

//--- tb/sfdpr_top_bench.sv
// Bench: reads the parameter store through the host model
`timescale 1ns/1ps

module sfdpr_top_bench;
  import sfdpr_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        go        = 1'b0;
  logic [15:0] a         = 16'h0000;
  logic        req, vld, hit;
  logic [15:0] addr;
  logic [7:0]  dat;
  logic [16:0] pp [2]    = '{default: 17'h0};
  int          n_fail    = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  logic [7:0]  tbl [14]  = '{8'ha5, 8'hb0, 8'he7, 8'hff, 8'hfb, 8'hff, 8'hff,
                            8'hff, 8'hff, 8'h03, 8'h48, 8'heb, 8'h08, 8'h6b};
  always #10 ref_clk_i = ~ref_clk_i;
  sfdpr_host host_u (.clk_i(ref_clk_i), .rst_n_i, .go_i(go), .a_i(a),
    .req_o(req), .addr_o(addr));
  sfdpr_top dut_u (.ref_clk_i, .rst_n_i, .rd_req_i(req), .rd_addr_i(addr),
    .rd_valid_o(vld), .rd_hit_o(hit), .rd_data_o(dat));
  function automatic logic in_t(logic [15:0] x);
    return x >= 16'h108e && x <= 16'h109b;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Each taken request is judged when its answer stands: a request seen
  // here is taken at the next edge and answers two negedges later
  always @(negedge ref_clk_i)
  begin
    if (!rst_n_i)
      pp <= '{default: 17'h0};
    else
    begin
      chk("valid", {7'h0, vld}, {7'h0, pp[1][16]});
      if (pp[1][16])
      begin
        chk("hit", {7'h0, hit}, {7'h0, in_t(pp[1][15:0])});
        chk("data", dat, in_t(pp[1][15:0]) ? tbl[pp[1][15:0] - 16'h108e]
          : 8'hff);
      end
      pp <= '{{req, addr}, pp[0]};
    end
  end
  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic send(logic [15:0] x);
    @(posedge ref_clk_i);
    go <= 1'b1;
    a  <= x;
  endtask
  task automatic idle(int n);
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Whole CFI view, back to back
  task automatic t_cfi();
    for (int i = 0; i < 14; i++) send(16'h108e + i[15:0]);
    idle(5);
  endtask
  // SFDP view, spaced requests
  task automatic t_sfdp();
    for (int i = 0; i < 12; i++)
    begin
      send(16'h1090 + i[15:0]);
      idle(1);
    end
    idle(4);
  endtask
  // Just outside the table, and the parameter start
  task automatic t_miss();
    send(16'h108d);
    send(16'h109c);
    send(16'h1000);
    send(16'hffff);
    idle(5);
  endtask
  // Contents survive a reset in mid-run
  task automatic t_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_cfi();
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_cfi();
    t_sfdp();
    t_miss();
    t_reset();
    report_and_stop();
  end
endmodule

bind sfdpr_top sfdpr_top_chk chk_u (.ref_clk_i, .rst_n_i, .rd_req_i,
  .rd_addr_i, .rd_valid_o, .rd_hit_o, .rd_data_o);
